/* File: shared/uart_page_consts.svh */
// register offsets, access values and field positions for the page decoder
// assumes inclusion by bare name from design and bench files
`ifndef UART_PAGE_CONSTS_SVH
`define UART_PAGE_CONSTS_SVH

`define OFS_DIVISOR_LOW      3'h0
`define OFS_DIVISOR_HIGH     3'h1
`define OFS_ENHANCED         3'h2
`define OFS_LINE_CONTROL     3'h3
`define OFS_MODEM_CONTROL    3'h4
`define OFS_RESUME_ONE       3'h4
`define OFS_RESUME_TWO       3'h5
`define OFS_PAUSE_ONE        3'h6
`define OFS_FLOW_THRESHOLD   3'h6
`define OFS_PAUSE_TWO        3'h7
`define OFS_TRIGGER_LEVELS   3'h7
`define OFS_FIFO_READY       3'h7

`define LINE_DIVISOR_PAGE    8'h80
`define LINE_ENHANCED_PAGE   8'hBF
`define LINE_PLAIN_PAGE      8'h00
`define FEATURE_ENHANCE_BIT  4
`define MODEM_THRESH_BIT     6
`define MODEM_READY_BIT      4
`define REG_RESET            8'h00

`endif

/* File: shared/uart_page_pkg.sv */
// types for the page decoder
// assumes nothing of its surroundings
package uart_page_pkg;

    typedef enum logic [2:0]
    {
        page_base_type_e    = 3'b000,
        page_divisor        = 3'b001,
        page_enhanced       = 3'b011,
        page_threshold      = 3'b010,
        page_ready          = 3'b110
    } page_type;

    typedef struct packed
    {
        logic [2:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } host_req_type;

endpackage

/* File: src/uart_register_page_decode.sv */
// register page decode for one channel: host bus, page selection, register bank
// assumes the host strobes are synchronous to clk_sys, one cycle per access
`timescale 1ns/10ps
`include "uart_page_consts.svh"

// Overview of operation
// - line control 0x80 turns offset 0 into the divisor low byte
// - line control 0x80 turns offset 1 into the divisor high byte
// - line control 0xBF maps offset 6 to pause one, 4 to resume one
// - line control 0xBF maps offset 7 to pause two, 5 to resume two
// - line control 0xBF maps offset 2 to the enhanced feature register
// - enhance bit, modem bit 6 and line control 0 expose threshold at 6
// - same conditions expose fifo trigger levels at offset 7
// - modem bit 4 cleared by mask EF exposes fifo ready status at 7
// - line control at offset 3 reads back its written value
// - modem control at offset 4 reads back its written value
// - base registers by address alone; extended ones also need access values
module uart_register_page_decode
#(
    parameter int unsigned DATA_W = 8
)
(
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire uart_page_pkg::host_req_type host_req,
    input  wire logic [DATA_W-1:0]           base_rdata,
    input  wire logic [DATA_W-1:0]           fifo_ready_status,
    output logic      [DATA_W-1:0]           rdata,
    output logic                             rvalid,
    output logic                             base_wr,
    output logic                             base_rd,
    output logic      [2:0]                  base_addr,
    output logic      [DATA_W-1:0]           base_wdata,
    output logic      [DATA_W-1:0]           divisor_low,
    output logic      [DATA_W-1:0]           divisor_high,
    output logic      [DATA_W-1:0]           enhanced_feature_control,
    output logic      [DATA_W-1:0]           line_control,
    output logic      [DATA_W-1:0]           modem_control,
    output logic      [DATA_W-1:0]           resume_char_one,
    output logic      [DATA_W-1:0]           resume_char_two,
    output logic      [DATA_W-1:0]           pause_char_one,
    output logic      [DATA_W-1:0]           pause_char_two,
    output logic      [DATA_W-1:0]           flow_threshold,
    output logic      [DATA_W-1:0]           fifo_trigger_levels,
    output uart_page_pkg::page_type          page
);
    import uart_page_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] div_lo_q;
    logic [DATA_W-1:0] dlh_q;
    logic [DATA_W-1:0] efc_q;
    logic [DATA_W-1:0] line_q;
    logic [DATA_W-1:0] modem_q;
    logic [DATA_W-1:0] ron_q;
    logic [DATA_W-1:0] rtw_q;
    logic [DATA_W-1:0] pon_q;
    logic [DATA_W-1:0] ptw_q;
    logic [DATA_W-1:0] thr_q;
    logic [DATA_W-1:0] tlv_q;
    logic [DATA_W-1:0] rdata_q;
    logic              rvalid_q;
    logic              base_wr_q;
    logic              base_rd_q;
    logic [2:0]        base_addr_q;
    logic [DATA_W-1:0] base_wdata_q;
    logic              pend_base_rd_q;
    page_type          page_q;
    page_type          page_d;

    // ------------------------------------------------------------
    // request fields
    // ------------------------------------------------------------
    // host strobes come from logic on clk_sys, so no synchroniser stands here
    logic [2:0]        a;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wd;

    assign a  = host_req.addr;
    assign wr = host_req.wr;
    assign rd = host_req.rd;
    assign wd = host_req.wdata[DATA_W-1:0];

    // ------------------------------------------------------------
    // page selection
    // ------------------------------------------------------------
    // the page is decoded from present register contents each cycle, so a
    // write to line control takes effect for the very next access
    // the checks run in priority order: line control at 0x80 or 0xBF
    // always opens its page, whatever the enable bits hold
    function automatic page_type decode_page
    (
        input logic [DATA_W-1:0] line,
        input logic [DATA_W-1:0] efc,
        input logic [DATA_W-1:0] modem
    );
        page_type p;
        p = page_base_type_e;
        if (line == `LINE_DIVISOR_PAGE)
            p = page_divisor;
        else if (line == `LINE_ENHANCED_PAGE)
            p = page_enhanced;
        else if (efc[`FEATURE_ENHANCE_BIT] && modem[`MODEM_THRESH_BIT]
                 && line == `LINE_PLAIN_PAGE)
            p = page_threshold;
        else if (!modem[`MODEM_READY_BIT])
            p = page_ready;
        return p;
    endfunction

    always_comb
    begin
        page_d = decode_page(line_q, efc_q, modem_q);
    end

    // page is a registered copy for observation only; the decode above
    // never waits for it, which is why it trails the registers by a cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            page_q <= page_base_type_e;
        else
            page_q <= page_d;
    end

    // ------------------------------------------------------------
    // extended register writes
    // ------------------------------------------------------------
    // an offset that the page does not claim falls through to the base set,
    // so a stray write never lands in a hidden register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_lo_q <= `REG_RESET;
            dlh_q <= `REG_RESET;
            efc_q <= `REG_RESET;
            ron_q <= `REG_RESET;
            rtw_q <= `REG_RESET;
            pon_q <= `REG_RESET;
            ptw_q <= `REG_RESET;
            thr_q <= `REG_RESET;
            tlv_q <= `REG_RESET;
        end
        else if (wr)
        begin
            case (page_d)
                page_divisor:
                begin
                    if (a == `OFS_DIVISOR_LOW)
                        div_lo_q <= wd;
                    else if (a == `OFS_DIVISOR_HIGH)
                        dlh_q <= wd;
                end
                page_enhanced:
                begin
                    if (a == `OFS_ENHANCED)
                        efc_q <= wd;
                    else if (a == `OFS_RESUME_ONE)
                        ron_q <= wd;
                    else if (a == `OFS_RESUME_TWO)
                        rtw_q <= wd;
                    else if (a == `OFS_PAUSE_ONE)
                        pon_q <= wd;
                    else if (a == `OFS_PAUSE_TWO)
                        ptw_q <= wd;
                end
                page_threshold:
                begin
                    if (a == `OFS_FLOW_THRESHOLD)
                        thr_q <= wd;
                    else if (a == `OFS_TRIGGER_LEVELS)
                        tlv_q <= wd;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // line control reachable on every page, modem control on all but the 0xBF page
    // ------------------------------------------------------------
    // modem control shares offset 4 with resume one, so it is hidden on
    // the 0xBF page only; line control is never hidden
    // neither belongs to the base set, so their writes never raise base_wr
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            line_q <= `REG_RESET;
        else if (wr && a == `OFS_LINE_CONTROL)
            line_q <= wd;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            modem_q <= `REG_RESET;
        else if (wr && a == `OFS_MODEM_CONTROL && page_d != page_enhanced)
            modem_q <= wd;
    end

    // ------------------------------------------------------------
    // read mux and base pass-through
    // ------------------------------------------------------------
    // an access is extended when the page claims its offset; anything else
    // falls through to the base register set
    function automatic logic is_ext
    (
        input page_type p,
        input logic [2:0] adr,
        input logic       is_rd
    );
        logic r;
        r = 1'b0;
        case (p)
            page_divisor:
                r = (adr == `OFS_DIVISOR_LOW) || (adr == `OFS_DIVISOR_HIGH);
            page_enhanced:
                r = (adr == `OFS_ENHANCED) || (adr >= `OFS_RESUME_ONE);
            page_threshold:
                r = (adr == `OFS_FLOW_THRESHOLD) || (adr == `OFS_TRIGGER_LEVELS);
            page_ready:
                r = is_rd && (adr == `OFS_FIFO_READY);
            default:
                r = 1'b0;
        endcase
        if (adr == `OFS_LINE_CONTROL)
            r = 1'b1;
        if (adr == `OFS_MODEM_CONTROL && p != page_enhanced)
            r = 1'b1;
        return r;
    endfunction

    // limitation: an extended read taken on the edge at which a base read
    // answers replaces that answer, so the host waits for rvalid between reads
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rdata_q        <= `REG_RESET;
            rvalid_q       <= 1'b0;
            pend_base_rd_q <= 1'b0;
        end
        else
        begin
            rvalid_q       <= 1'b0;
            pend_base_rd_q <= 1'b0;
            if (pend_base_rd_q)
            begin
                rdata_q  <= base_rdata;
                rvalid_q <= 1'b1;
            end
            if (rd && is_ext(page_d, a, 1'b1))
            begin
                rvalid_q <= 1'b1;
                if (a == `OFS_LINE_CONTROL)
                    rdata_q <= line_q;
                else if (a == `OFS_MODEM_CONTROL && page_d != page_enhanced)
                    rdata_q <= modem_q;
                else
                begin
                    case (page_d)
                        page_divisor:
                            rdata_q <= (a == `OFS_DIVISOR_LOW) ? div_lo_q : dlh_q;
                        page_enhanced:
                        begin
                            if (a == `OFS_ENHANCED)
                                rdata_q <= efc_q;
                            else if (a == `OFS_RESUME_ONE)
                                rdata_q <= ron_q;
                            else if (a == `OFS_RESUME_TWO)
                                rdata_q <= rtw_q;
                            else if (a == `OFS_PAUSE_ONE)
                                rdata_q <= pon_q;
                            else
                                rdata_q <= ptw_q;
                        end
                        page_threshold:
                            rdata_q <= (a == `OFS_FLOW_THRESHOLD) ? thr_q : tlv_q;
                        default:
                            rdata_q <= fifo_ready_status;
                    endcase
                end
            end
            else if (rd)
                pend_base_rd_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // base pass-through strobes
    // ------------------------------------------------------------
    // base strobes are registered; base_rdata must answer the cycle after
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            base_wr_q    <= 1'b0;
            base_rd_q    <= 1'b0;
            base_addr_q  <= 3'h0;
            base_wdata_q <= `REG_RESET;
        end
        else
        begin
            base_wr_q    <= wr && !is_ext(page_d, a, 1'b0);
            base_rd_q    <= rd && !is_ext(page_d, a, 1'b1);
            base_addr_q  <= a;
            base_wdata_q <= wd;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a plain copy of a flop, so the host never sees decode glitches
    assign rdata                    = rdata_q;
    assign rvalid                   = rvalid_q;
    assign base_wr                  = base_wr_q;
    assign base_rd                  = base_rd_q;
    assign base_addr                = base_addr_q;
    assign base_wdata               = base_wdata_q;
    assign divisor_low              = div_lo_q;
    assign divisor_high             = dlh_q;
    assign enhanced_feature_control = efc_q;
    assign line_control             = line_q;
    assign modem_control            = modem_q;
    assign resume_char_one          = ron_q;
    assign resume_char_two          = rtw_q;
    assign pause_char_one           = pon_q;
    assign pause_char_two           = ptw_q;
    assign flow_threshold           = thr_q;
    assign fifo_trigger_levels      = tlv_q;
    assign page                     = page_q;

endmodule

/* File: test/base_reg_model.sv */
// far-side model: the base register set behind base_wr / base_rd
// assumes one clock domain and read data sampled while base_rd is high
`timescale 1ns/10ps

module base_reg_model
(
    input  wire logic       clk_sys,
    input  wire logic       base_wr,
    input  wire logic       base_rd,
    input  wire logic [2:0] base_addr,
    input  wire logic [7:0] base_wdata,
    output logic      [7:0] base_rdata
);
    logic [7:0] mem_q [8];
    logic [7:0] junk_q = 8'h5A;

    // ----------------------------------------
    // storage and read path
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        junk_q <= ~junk_q + 8'h01;
        if (base_wr)
        begin
            mem_q[base_addr] <= base_wdata;
        end
    end

    // outside a read the bus shows a changing pattern, never a stale value
    assign base_rdata = base_rd ? mem_q[base_addr] : junk_q;
endmodule

/* File: test/page_decode_chk.sv */
// checker for the page decoder, bound to the top module
// assumes the constants header is on the include path
`timescale 1ns/10ps
`include "uart_page_consts.svh"

module page_decode_chk
#(
    parameter int unsigned DATA_W = 8
)
(
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire uart_page_pkg::host_req_type host_req,
    input  wire logic [DATA_W-1:0]           fifo_ready_status,
    input  wire logic [DATA_W-1:0]           rdata,
    input  wire logic                        rvalid,
    input  wire logic                        base_wr,
    input  wire logic                        base_rd,
    input  wire logic [2:0]                  base_addr,
    input  wire logic [DATA_W-1:0]           divisor_low,
    input  wire logic [DATA_W-1:0]           divisor_high,
    input  wire logic [DATA_W-1:0]           enhanced_feature_control,
    input  wire logic [DATA_W-1:0]           line_control,
    input  wire logic [DATA_W-1:0]           modem_control,
    input  wire logic [DATA_W-1:0]           resume_char_two,
    input  wire logic [DATA_W-1:0]           pause_char_one,
    input  wire logic [DATA_W-1:0]           flow_threshold,
    input  wire logic [DATA_W-1:0]           fifo_trigger_levels
);
    import uart_page_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic wr;
    logic [2:0] ad;
    logic div_pg;
    logic enh_pg;
    logic thr_pg;
    assign wr = host_req.wr;
    assign ad = host_req.addr;
    assign div_pg = line_control == `LINE_DIVISOR_PAGE;
    assign enh_pg = line_control == `LINE_ENHANCED_PAGE;
    assign thr_pg = enhanced_feature_control[`FEATURE_ENHANCE_BIT] &&
                    modem_control[`MODEM_THRESH_BIT] && line_control == `LINE_PLAIN_PAGE;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_div_low;
        wr && ad == 3'h0 && div_pg |=> divisor_low == $past(host_req.wdata);
    endproperty
    a_div_low: assert property (p_div_low) else $error("divisor low not written");
    property p_div_high;
        wr && ad == 3'h1 && div_pg |=> divisor_high == $past(host_req.wdata);
    endproperty
    a_div_high: assert property (p_div_high) else $error("divisor high not written");
    property p_pause_one;
        wr && ad == 3'h6 && enh_pg |=> pause_char_one == $past(host_req.wdata);
    endproperty
    a_pause_one: assert property (p_pause_one) else $error("pause one not written");
    property p_resume_two;
        wr && ad == 3'h5 && enh_pg |=> resume_char_two == $past(host_req.wdata);
    endproperty
    a_resume_two: assert property (p_resume_two) else $error("resume two not written");
    property p_enh;
        wr && ad == 3'h2 && enh_pg |=> enhanced_feature_control == $past(host_req.wdata);
    endproperty
    a_enh: assert property (p_enh) else $error("enhanced feature not written");
    property p_thr;
        wr && ad == 3'h6 && thr_pg |=> flow_threshold == $past(host_req.wdata);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold not written");
    property p_trig;
        wr && ad == 3'h7 && thr_pg |=> fifo_trigger_levels == $past(host_req.wdata);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger levels not written");
    property p_ready;
        host_req.rd && ad == 3'h7 && !div_pg && !enh_pg && !thr_pg
            && !modem_control[`MODEM_READY_BIT]
            |=> rvalid && rdata == $past(fifo_ready_status);
    endproperty
    a_ready: assert property (p_ready) else $error("ready status not returned");
    property p_lcr;
        wr && ad == 3'h3 |=> line_control == $past(host_req.wdata);
    endproperty
    a_lcr: assert property (p_lcr) else $error("line control not written");
    property p_modem;
        wr && ad == 3'h4 && !enh_pg |=> modem_control == $past(host_req.wdata);
    endproperty
    a_modem: assert property (p_modem) else $error("modem control not written");
    property p_base;
        wr && !div_pg && !enh_pg && ad inside {3'h0, 3'h1, 3'h2, 3'h5}
            |=> base_wr && base_addr == $past(ad);
    endproperty
    a_base: assert property (p_base) else $error("base write not passed on");
    property p_base_rd;
        base_rd |=> rvalid;
    endproperty
    a_base_rd: assert property (p_base_rd) else $error("base read not answered");
endmodule

bind uart_register_page_decode page_decode_chk #(.DATA_W(DATA_W)) i_chk
(
    .clk_sys(clk_sys), .reset(reset), .host_req(host_req),
    .fifo_ready_status(fifo_ready_status), .rdata(rdata), .rvalid(rvalid),
    .base_wr(base_wr), .base_rd(base_rd), .base_addr(base_addr),
    .divisor_low(divisor_low), .divisor_high(divisor_high),
    .enhanced_feature_control(enhanced_feature_control), .line_control(line_control),
    .modem_control(modem_control), .resume_char_two(resume_char_two),
    .pause_char_one(pause_char_one), .flow_threshold(flow_threshold),
    .fifo_trigger_levels(fifo_trigger_levels)
);

/* File: test/tb_top.sv */
// testbench: host accesses through every register page, base set model behind
// assumes the design, package, checker and model are compiled before it
`timescale 1ns/10ps

module tb_top;
    import uart_page_pkg::*;

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    host_req_type req = '0;
    logic [7:0] base_rdata;
    logic [7:0] status = 8'hC3;
    logic [7:0] rdata, base_wdata, div_lo, div_hi, efc, line, modem;
    logic [7:0] res1, res2, pau1, pau2, thr, trig;
    logic rvalid, base_wr, base_rd;
    logic [2:0] base_addr;
    page_type page;
    int miscompares = 0;
    int num_checks = 0;

    initial forever #2 clk_sys = ~clk_sys;

    uart_register_page_decode #(.DATA_W(8)) i_dut
    (
        .clk_sys(clk_sys), .reset(reset), .host_req(req), .base_rdata(base_rdata),
        .fifo_ready_status(status), .rdata(rdata), .rvalid(rvalid), .base_wr(base_wr),
        .base_rd(base_rd), .base_addr(base_addr), .base_wdata(base_wdata),
        .divisor_low(div_lo), .divisor_high(div_hi), .enhanced_feature_control(efc),
        .line_control(line), .modem_control(modem), .resume_char_one(res1),
        .resume_char_two(res2), .pause_char_one(pau1), .pause_char_two(pau2),
        .flow_threshold(thr), .fifo_trigger_levels(trig), .page(page)
    );

    base_reg_model i_base
    (
        .clk_sys(clk_sys), .base_wr(base_wr), .base_rd(base_rd), .base_addr(base_addr),
        .base_wdata(base_wdata), .base_rdata(base_rdata)
    );

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask

    // the answer is judged at a falling edge, where rvalid has settled
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        int n;
        @(negedge clk_sys);
        req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        @(negedge clk_sys);
        req.rd = 1'b0;
        for (n = 0; n < 4 && rvalid !== 1'b1; n++)
            @(negedge clk_sys);
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        check(line, 8'h00);
        check(modem, 8'h00);
        check(div_lo | div_hi | efc | thr | trig, 8'h00);
        rd(3'h3, 8'h00);
        check(8'(page), 8'(page_ready));
    endtask

    task automatic t_divisor;
        wr(3'h3, 8'h80);
        wr(3'h0, 8'hA5);
        wr(3'h1, 8'h3C);
        check(div_lo, 8'hA5);
        check(div_hi, 8'h3C);
        rd(3'h0, 8'hA5);
        rd(3'h1, 8'h3C);
        rd(3'h3, 8'h80);
        check(8'(page), 8'(page_divisor));
    endtask

    task automatic t_xchar;
        wr(3'h3, 8'hBF);
        wr(3'h6, 8'h11);
        wr(3'h4, 8'h22);
        wr(3'h7, 8'h33);
        wr(3'h5, 8'h44);
        wr(3'h2, 8'h05);
        check(pau1, 8'h11);
        check(res1, 8'h22);
        check(pau2, 8'h33);
        check(res2, 8'h44);
        rd(3'h2, 8'h05);
        check(modem, 8'h00);
        wr(3'h3, 8'h03);
    endtask

    task automatic t_thresh;
        wr(3'h3, 8'hBF);
        rd(3'h2, 8'h05);
        wr(3'h2, 8'h15);
        wr(3'h3, 8'h00);
        rd(3'h4, 8'h00);
        wr(3'h4, 8'h40);
        wr(3'h6, 8'h66);
        wr(3'h7, 8'h77);
        check(thr, 8'h66);
        check(trig, 8'h77);
        rd(3'h6, 8'h66);
        rd(3'h7, 8'h77);
        check(8'(page), 8'(page_threshold));
        check(pau1, 8'h11);
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h05);
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h00);
        check(efc, 8'h05);
    endtask

    task automatic t_ready;
        wr(3'h4, 8'h13);
        rd(3'h4, 8'h13);
        wr(3'h7, 8'h7E);
        rd(3'h7, 8'h7E);
        wr(3'h4, 8'h13 & 8'hEF);
        rd(3'h7, 8'hC3);
        check(8'(page), 8'(page_ready));
        status = 8'h96;
        rd(3'h7, 8'h96);
        wr(3'h4, 8'h13);
        rd(3'h7, 8'h7E);
    endtask

    task automatic t_base;
        wr(3'h0, 8'h99);
        wr(3'h5, 8'h4D);
        rd(3'h0, 8'h99);
        rd(3'h5, 8'h4D);
        check(div_lo, 8'hA5);
        check(res2, 8'h44);
        wr(3'h3, 8'h80);
        rd(3'h0, 8'hA5);
        wr(3'h3, 8'h03);
        rd(3'h0, 8'h99);
        check(8'(page), 8'(page_base_type_e));
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        // reset values are only checked; later scenarios rely on values that earlier ones wrote
        t_reset();
        t_divisor();
        t_xchar();
        t_thresh();
        t_ready();
        t_base();
        end_of_test();
    end

    initial
    begin
        #20000;
        miscompares++;
        end_of_test();
    end
endmodule
